/* afe_clk_pkg.sv */
package afe_clk_pkg;
    // Setup register field layout
    localparam int OSR_LSB = 0;
    localparam int PRE_LSB = 3;
    localparam int EXT_BIT = 5;
    localparam int SETUP_W = 6;
    // Values after reset: crystal, divide by 1, ratio 256
    localparam logic [2:0] OSR_RESET = 3'h3;
    localparam logic [1:0] PRE_RESET = 2'h0;
    localparam logic EXT_RESET = 1'b0;
    localparam logic [SETUP_W-1:0] SETUP_RESET = {EXT_RESET, PRE_RESET, OSR_RESET};
    // Counter layout and fixed divide ratios
    localparam logic [1:0] SAMPLE_DIV_LAST = 2'h3;
    localparam logic [11:0] OSR_MIN = 12'h020;
    localparam logic [2:0] PRE_ONE = 3'h1;
    localparam logic [1:0] STROBE_STAGE_LAST = 2'h1;
    // Primary clock idle detection window
    localparam int SYS_CLK_PERIOD_NS = 50;
    localparam int MCLK_IDLE_NS = 1000;
    localparam int MCLK_IDLE_CYCLES = MCLK_IDLE_NS / SYS_CLK_PERIOD_NS;
    localparam logic [4:0] IDLE_LAST = 5'(MCLK_IDLE_CYCLES - 1);
endpackage : afe_clk_pkg

// Primary clock events from the source selector to the divider chain
interface clk_src_if;
    logic mclk_tick;
    logic mclk_running;
    logic ext_sel;
    modport src (output mclk_tick, output mclk_running, input ext_sel);
    modport core (input mclk_tick, input mclk_running, output ext_sel);
endinterface : clk_src_if

/* afe_clk_source_model.sv */
module afe_clk_source_model (
    input wire logic i_clk_sys,
    input wire logic i_run,
    input wire logic [3:0] i_xtal_half,
    input wire logic [3:0] i_pin_half,
    output logic o_crystal_clk,
    output logic o_clock_input_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int xc = 0;
    int pc = 0;
    initial o_crystal_clk = 1'b0;
    initial o_clock_input_pin = 1'b0;
    // Both sources run freely while converting; a stopped source rests low
    always @(posedge i_clk_sys) begin
        xc <= (i_run && xc + 1 < i_xtal_half) ? xc + 1 : 0;
        pc <= (i_run && pc + 1 < i_pin_half) ? pc + 1 : 0;
        if (!i_run || xc + 1 >= i_xtal_half) o_crystal_clk <= i_run & ~o_crystal_clk;
        if (!i_run || pc + 1 >= i_pin_half) o_clock_input_pin <= i_run & ~o_clock_input_pin;
    end
endmodule // afe_clk_source_model

/* afe_clock_reset_chain.sv */
module afe_clock_reset_chain (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_master_reset_n,
    input wire logic i_crystal_clk,
    input wire logic i_clock_input_pin,
    input wire logic i_setup_write,
    input wire logic [afe_clk_pkg::SETUP_W-1:0] i_setup_data,
    output logic [afe_clk_pkg::SETUP_W-1:0] o_setup,
    output logic o_serial_access_en,
    output logic o_bias_enable,
    output logic o_input_clock_en,
    output logic o_core_clock_en,
    output logic o_analog_stage_clock,
    output logic o_sample_clock,
    output logic o_output_rate_clock,
    output logic o_conversion_done_strobe_n
);
    import afe_clk_pkg::*;

    clk_src_if src ();

    logic [SETUP_W-1:0] setup_q;
    logic master_on;
    logic [1:0] pre_sel;
    logic [2:0] osr_sel;
    logic [2:0] prescale_last;
    logic [11:0] osr_last;
    logic [2:0] pre_cnt_q;
    logic [1:0] dm_cnt_q;
    logic [11:0] osr_cnt_q;
    logic [1:0] str_cnt_q;
    logic stage_en;
    logic sample_en;
    logic rate_en;
    logic strobe_n_q;
    logic serial_en_q;

    clk_source_select u_src (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_crystal_clk(i_crystal_clk),
        .i_clock_input_pin(i_clock_input_pin),
        .bus(src)
    );

    assign master_on = i_master_reset_n;
    assign pre_sel = setup_q[PRE_LSB +: 2];
    assign osr_sel = setup_q[OSR_LSB +: 3];
    assign src.ext_sel = setup_q[EXT_BIT];

    // Setup register: defaults in reset, writes refused while held
    // Write strobe arrives already moved into this domain by the serial side
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            setup_q <= SETUP_RESET;
        end else if (!master_on) begin
            setup_q <= SETUP_RESET;
        end else if (i_setup_write) begin
            setup_q <= i_setup_data;
        end
    end

    // Serial access permission follows master reset
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            serial_en_q <= 1'b0;
        end else begin
            serial_en_q <= master_on;
        end
    end

    // Divide limits from the setup fields
    assign prescale_last = 3'((PRE_ONE << pre_sel) - PRE_ONE);
    assign osr_last = 12'((OSR_MIN << osr_sel) - 12'h001);

    // Enable pulses of each divided rate
    assign stage_en = master_on && src.mclk_tick && (pre_cnt_q >= prescale_last);
    assign sample_en = stage_en && (dm_cnt_q == SAMPLE_DIV_LAST);
    assign rate_en = sample_en && (osr_cnt_q >= osr_last);

    // Prescaler counter
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pre_cnt_q <= 3'h0;
        end else if (!master_on || stage_en) begin
            pre_cnt_q <= 3'h0;
        end else if (src.mclk_tick) begin
            pre_cnt_q <= pre_cnt_q + 3'h1;
        end
    end

    // Divide-by-four counter
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dm_cnt_q <= 2'h0;
        end else if (!master_on) begin
            dm_cnt_q <= 2'h0;
        end else if (stage_en) begin
            dm_cnt_q <= dm_cnt_q + 2'h1;
        end
    end

    // Oversampling counter
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            osr_cnt_q <= 12'h000;
        end else if (!master_on || rate_en) begin
            osr_cnt_q <= 12'h000;
        end else if (sample_en) begin
            osr_cnt_q <= osr_cnt_q + 12'h001;
        end
    end

    // Conversion-done strobe: low for two analog stage periods
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            strobe_n_q <= 1'b1;
            str_cnt_q <= 2'h0;
        end else if (!master_on) begin
            strobe_n_q <= 1'b1;
            str_cnt_q <= 2'h0;
        end else if (rate_en) begin
            strobe_n_q <= 1'b0;
            str_cnt_q <= 2'h0;
        end else if (!strobe_n_q && stage_en) begin
            if (str_cnt_q == STROBE_STAGE_LAST) begin
                strobe_n_q <= 1'b1;
            end
            str_cnt_q <= str_cnt_q + 2'h1;
        end
    end

    // Clock gating and bias outputs
    assign o_input_clock_en = src.mclk_tick && src.mclk_running;
    assign o_core_clock_en = master_on && src.mclk_tick;
    assign o_bias_enable = 1'b1;
    assign o_analog_stage_clock = stage_en;
    assign o_sample_clock = sample_en;
    assign o_output_rate_clock = rate_en;
    assign o_conversion_done_strobe_n = strobe_n_q;
    assign o_serial_access_en = serial_en_q;
    assign o_setup = setup_q;

    // Helper: setup written since the last analog stage pulse
    // A mid-period change can shorten or stretch that period, so its length is not checked
    logic pre_moved_q;
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pre_moved_q <= 1'b0;
        end else if (!master_on) begin
            pre_moved_q <= 1'b0;
        end else if (i_setup_write) begin
            pre_moved_q <= 1'b1;
        end else if (stage_en) begin
            pre_moved_q <= 1'b0;
        end
    end

    // Helper: setup written since the last output rate pulse
    logic osr_moved_q;
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            osr_moved_q <= 1'b0;
        end else if (!master_on) begin
            osr_moved_q <= 1'b0;
        end else if (i_setup_write) begin
            osr_moved_q <= 1'b1;
        end else if (rate_en) begin
            osr_moved_q <= 1'b0;
        end
    end

    // Helper: primary ticks since last analog stage pulse
    logic [3:0] tick_since_q;
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tick_since_q <= 4'h0;
        end else if (!master_on || stage_en) begin
            tick_since_q <= 4'h0;
        end else if (src.mclk_tick) begin
            tick_since_q <= tick_since_q + 4'h1;
        end
    end

    a_reset_defaults: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !i_master_reset_n |=> o_setup == SETUP_RESET && !o_serial_access_en)
        else $error("setup not defaulted in master reset");
    a_write_blocked: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !i_master_reset_n && i_setup_write |=> o_setup == SETUP_RESET)
        else $error("write taken during master reset");
    a_core_gated: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !i_master_reset_n |-> !o_core_clock_en && !o_analog_stage_clock ##1 o_conversion_done_strobe_n)
        else $error("clock distributed in master reset");
    a_input_idle: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !src.mclk_running |-> !o_input_clock_en)
        else $error("input clock while primary idle");
    a_bias_on: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        o_bias_enable)
        else $error("bias dropped");
    a_prescale_div: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        o_analog_stage_clock && !pre_moved_q |-> tick_since_q == {1'b0, prescale_last})
        else $error("prescale ratio wrong");
    a_sample_div: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        o_sample_clock |-> o_analog_stage_clock && dm_cnt_q == 2'h3)
        else $error("sample divide wrong");
    a_rate_div: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        o_output_rate_clock && !osr_moved_q |-> o_sample_clock && osr_cnt_q == osr_last)
        else $error("oversampling divide wrong");
    a_osr_map: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        osr_sel == 3'h7 |-> osr_last == 12'hFFF)
        else $error("ratio map wrong");
    a_strobe_start: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        o_output_rate_clock && i_master_reset_n |=> !o_conversion_done_strobe_n)
        else $error("strobe missing");
    a_strobe_end: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !o_conversion_done_strobe_n && o_analog_stage_clock && str_cnt_q == 2'h1 && !o_output_rate_clock
        |=> o_conversion_done_strobe_n)
        else $error("strobe width wrong");
    a_restart_zero: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $rose(i_master_reset_n) |-> pre_cnt_q == 3'h0 && dm_cnt_q == 2'h0 && osr_cnt_q == 12'h000)
        else $error("counters not cleared");

    c_strobe: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $fell(o_conversion_done_strobe_n));
    c_ext_clock: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        src.ext_sel && o_output_rate_clock);
    c_reset_release: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $rose(i_master_reset_n));
endmodule // afe_clock_reset_chain

/* afe_clock_reset_chain_tb.sv */
module afe_clock_reset_chain_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import afe_clk_pkg::*;
    logic clk = 0, rst_n = 0, mr_n = 0, wr = 0, run = 0;
    logic [5:0] wdata = 6'h00;
    logic [3:0] xh = 4'h1, ph = 4'h1;
    logic xtal, pin, inen, coren, an_o, sm_o, rt_o, ser_o, bias_o, done_n;
    logic [5:0] setup_o, ms = SETUP_RESET;
    logic [31:0] seed = 32'hBACF;
    logic sel, prev = 0, raw, tick, an, sm, rt, sn = 1, ser = 0;
    int idle = MCLK_IDLE_CYCLES - 1;
    int pc = 0, ac = 0, oc = 0, hc = 0, inen_cnt = 0, rate_cnt = 0, cyc = 0;
    int error_cnt = 0, num_checks = 0;
    afe_clock_reset_chain u_dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_master_reset_n(mr_n),
        .i_crystal_clk(xtal), .i_clock_input_pin(pin), .i_setup_write(wr), .i_setup_data(wdata),
        .o_setup(setup_o), .o_serial_access_en(ser_o), .o_bias_enable(bias_o), .o_input_clock_en(inen),
        .o_core_clock_en(coren), .o_analog_stage_clock(an_o), .o_sample_clock(sm_o),
        .o_output_rate_clock(rt_o), .o_conversion_done_strobe_n(done_n));
    afe_clk_source_model u_src (.i_clk_sys(clk), .i_run(run), .i_xtal_half(xh), .i_pin_half(ph),
        .o_crystal_clk(xtal), .o_clock_input_pin(pin));
    always #25 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [5:0] got, input logic [5:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Expected outputs from the reference counters, compared between edges
    always @(negedge clk) begin
        sel = ms[EXT_BIT] ? pin : xtal;
        raw = sel && !prev;
        tick = raw && mr_n;
        an = tick && pc >= (1 << ms[PRE_LSB +: 2]) - 1;
        sm = an && ac == 3;
        rt = sm && oc >= (32 << ms[OSR_LSB +: 3]) - 1;
        inen_cnt += (inen === 1'b1);
        rate_cnt += (rt_o === 1'b1);
        chk(setup_o, ms);
        chk(ser_o, ser);
        chk(bias_o, 1'b1);
        chk(done_n, sn);
        if (rst_n) begin
            chk(inen, raw && idle != MCLK_IDLE_CYCLES - 1);
            chk(coren, tick);
            chk(an_o, an);
            chk(sm_o, sm);
            chk(rt_o, rt);
        end
    end
    // Reference counters advance on each primary tick
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n || !mr_n) begin
            pc = 0;
            ac = 0;
            oc = 0;
            hc = 0;
            ms = SETUP_RESET;
            sn = 1'b1;
        end else begin
            if (rt) begin
                sn = 1'b0;
                hc = 0;
            end else if (!sn && an) begin
                hc++;
                sn = (hc == 2);
            end
            if (tick) begin
                pc = an ? 0 : pc + 1;
                ac = sm ? 0 : ac + (an ? 1 : 0);
                oc = rt ? 0 : oc + (sm ? 1 : 0);
            end
            if (wr) ms = wdata;
        end
        prev = rst_n ? sel : 1'b0;
        // Primary clock idle window, independent of master reset
        idle = !rst_n ? MCLK_IDLE_CYCLES - 1 : raw ? 0 : (idle == MCLK_IDLE_CYCLES - 1) ? idle : idle + 1;
        ser = rst_n && mr_n;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            test_done();
        end
    end
    task automatic restart(input logic [5:0] d);
        mr_n <= 1'b0;
        repeat (3) @(posedge clk);
        mr_n <= 1'b1;
        @(posedge clk);
        wr <= 1'b1;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic wait_rate(input int n, input int lim);
        int start;
        int k;
        start = rate_cnt;
        for (k = 0; k < lim && rate_cnt - start < n; k++) @(posedge clk);
        chk(rate_cnt - start >= n, 1'b1);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        run <= 1'b1;
        repeat (10) @(posedge clk);
        wr <= 1'b1;
        wdata <= 6'h2D;
        @(posedge clk);
        wr <= 1'b0;
        repeat (30) @(posedge clk);
        chk(inen_cnt > 0, 1'b1);
        $display("test master reset done");
        for (int i = 0; i < 8; i++) begin
            restart({3'h0, 3'(i)});
            wait_rate(1, 40000);
        end
        $display("test ratio sweep done");
        for (int p = 0; p < 4; p++) begin
            restart({1'b0, 2'(p), 3'h0});
            wait_rate(2, 8000);
        end
        $display("test prescale sweep done");
        run <= 1'b0;
        ph <= 4'h2;
        restart(6'h28);
        run <= 1'b1;
        wait_rate(2, 6000);
        run <= 1'b0;
        restart(6'h00);
        run <= 1'b1;
        $display("test external clock done");
        for (int r = 0; r < 25; r++) begin
            seed = xs(seed);
            wr <= 1'b1;
            wdata <= {1'b0, seed[4:3], 1'b0, seed[1:0]};
            xh <= 4'(1 + seed[17:16]);
            mr_n <= ~(seed[20] & seed[21]);
            @(posedge clk);
            wr <= 1'b0;
            mr_n <= 1'b1;
            repeat (20 + seed[14:8]) @(posedge clk);
        end
        $display("test random traffic done");
        test_done();
    end
endmodule // afe_clock_reset_chain_tb

/* clk_source_select.sv */
module clk_source_select (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_crystal_clk,
    input wire logic i_clock_input_pin,
    clk_src_if.src bus
);
    import afe_clk_pkg::*;

    logic sel_now;
    logic sel_prev_q;
    logic [4:0] idle_cnt_q;

    // Pick crystal or direct input pin
    assign sel_now = bus.ext_sel ? i_clock_input_pin : i_crystal_clk;
    assign bus.mclk_tick = sel_now & ~sel_prev_q;

    // Previous level for rising edge detection
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sel_prev_q <= 1'b0;
        end else begin
            sel_prev_q <= sel_now;
        end
    end

    // Idle watchdog: clock counts as stopped after a quiet window
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            idle_cnt_q <= IDLE_LAST;
        end else if (bus.mclk_tick) begin
            idle_cnt_q <= 5'h00;
        end else if (idle_cnt_q != IDLE_LAST) begin
            idle_cnt_q <= idle_cnt_q + 5'h01;
        end
    end
    assign bus.mclk_running = (idle_cnt_q != IDLE_LAST);

    a_source_crystal: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !bus.ext_sel && i_crystal_clk && !$past(i_crystal_clk) && $stable(bus.ext_sel) |-> bus.mclk_tick)
        else $error("crystal edge missed");
    a_source_pin: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        bus.ext_sel && i_clock_input_pin && !$past(i_clock_input_pin) && $stable(bus.ext_sel) |-> bus.mclk_tick)
        else $error("input pin edge missed");
endmodule // clk_source_select
